//--- hdl/asq_ahb_top.sv
`timescale 1ns/100ps
`include "asq_cfg.svh"
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
// Summary of operation
// - Four enable bits, one per sequencer, each activates its sequencer.
// - Raw flag sets on completion of a sample with irq request bit while its sequencer is enabled.
// - Raw flags are always readable, independent of the mask.
// - One mask bit per sequencer gates the raw flag to the interrupt.
// - Masked status reads as raw AND mask.
// - Interrupt is a level, high while any raw AND mask is one.
// - Writing one to a status bit clears it and the raw flag.
// - That clear acts even when the masked bit is zero.
module asq_ahb_top
  import asq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Sequencer side.
  input wire logic [3:0] sample_done,
  input wire logic [3:0] sample_irq_request,
  output logic [3:0] sequencer_active_bit,
  // Interrupt.
  output logic adc_irq
);
  asq_bus_s b_q;
  asq_bus_s b_d;
  logic [3:0] raw_flags;
  logic [3:0] mask_bits;
  logic [3:0] mstat;
  logic wr_act;
  logic wr_msk;
  logic wr_clr;
  logic take;

  // ----------------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------------
  // Upper bits read as zero; unmapped offsets read as zero and answer OKAY.
  function automatic logic [31:0] rd_mux(input logic [11:0] a, input logic [3:0] act,
                                         input logic [3:0] raw, input logic [3:0] msk,
                                         input logic [3:0] ms);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `ASQ_OFS_ACTIVATE: v[3:0] = act;
      `ASQ_OFS_RAW: v[3:0] = raw;
      `ASQ_OFS_MASK: v[3:0] = msk;
      `ASQ_OFS_STATUS: v[3:0] = ms;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------------
  // Transfers complete with zero wait states, so hreadyout is always high.
  assign take = hsel && hready && htrans[1];

  // Address phase capture and data phase write strobes.
  always_comb begin
    b_d = b_q;
    b_d.phase = ASQ_IDLE;
    if (take) begin
      b_d.phase = ASQ_DATA;
      b_d.write = hwrite;
      b_d.addr = haddr[11:0];
      if (!hwrite) begin
        b_d.rdata = rd_mux(haddr[11:0], sequencer_active_bit, raw_flags, mask_bits, mstat);
      end
    end
  end

  // Read data leaves a register: it is sampled in the address phase, so a flag
  // that sets during the data phase shows on the next read.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      b_q <= '{phase: ASQ_IDLE, write: 1'b0, addr: 12'h000, rdata: 32'h0000_0000};
    end else begin
      b_q <= b_d;
    end
  end

  // Write strobes are valid in the data phase where hwdata stands.
  assign wr_act = (b_q.phase == ASQ_DATA) && b_q.write && (b_q.addr == `ASQ_OFS_ACTIVATE);
  assign wr_msk = (b_q.phase == ASQ_DATA) && b_q.write && (b_q.addr == `ASQ_OFS_MASK);
  assign wr_clr = (b_q.phase == ASQ_DATA) && b_q.write && (b_q.addr == `ASQ_OFS_STATUS);

  assign hrdata = b_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------------------
  // Flag core
  // ----------------------------------------------------------------------------
  asq_irq_core u_core (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wr_active(wr_act),
    .wr_mask(wr_msk),
    .wr_clear(wr_clr),
    .wr_data(hwdata[3:0]),
    .sample_done(sample_done),
    .sample_irq_request(sample_irq_request),
    .sequencer_active_bit(sequencer_active_bit),
    .raw_completion_flag(raw_flags),
    .irq_mask_q(mask_bits),
    .masked_status(mstat),
    .adc_irq(adc_irq)
  );

  a_act_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_act |=> sequencer_active_bit == $past(hwdata[3:0])) else $error("enable write");
  a_raw_readonly: assert property (@(posedge sys_clk) disable iff (!resetn)
    (b_q.phase == ASQ_DATA) && b_q.write && (b_q.addr == `ASQ_OFS_RAW) && sample_done == 4'h0
    |=> raw_flags == $past(raw_flags)) else $error("raw written");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    take && !hwrite && haddr[11:0] == `ASQ_OFS_STATUS |=> hrdata == {28'h0, $past(raw_flags & mask_bits)})
    else $error("status read");
endmodule

//--- hdl/asq_cfg.svh
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ASQ_OFS_ACTIVATE 12'h000
`define ASQ_OFS_RAW 12'h004
`define ASQ_OFS_MASK 12'h008
`define ASQ_OFS_STATUS 12'h00C
// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define ASQ_NSEQ 4
`define ASQ_FLD_LSB 0
`define ASQ_FLD_MSB 3
`define ASQ_RST_ACTIVATE 4'h0
`define ASQ_RST_RAW 4'h0
`define ASQ_RST_MASK 4'h0
`define ASQ_ADDR_W 12
`endif

//--- hdl/asq_irq_core.sv
`timescale 1ns/100ps
`include "asq_cfg.svh"
// Flag core: enables, raw completion flags, mask and the interrupt line.
module asq_irq_core
  import asq_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Software writes, one-cycle strobes.
  input wire logic wr_active,
  input wire logic wr_mask,
  input wire logic wr_clear,
  input wire logic [3:0] wr_data,
  // Sequencer side.
  input wire logic [3:0] sample_done,
  input wire logic [3:0] sample_irq_request,
  // State out.
  output logic [3:0] sequencer_active_bit,
  output logic [3:0] raw_completion_flag,
  output logic [3:0] irq_mask_q,
  output logic [3:0] masked_status,
  output logic adc_irq
);
  asq_regs_s r_q;
  asq_regs_s r_d;
  logic [3:0] set_ev;

  // Next state; set of a raw flag wins over a clear in the same cycle.
  always_comb begin
    r_d = r_q;
    set_ev = sample_done & sample_irq_request & r_q.active;
    if (wr_active) begin
      r_d.active = wr_data;
    end
    if (wr_mask) begin
      r_d.mask = wr_data;
    end
    // A one clears the raw flag whatever the mask; a zero leaves it alone.
    if (wr_clear) begin
      r_d.raw = r_q.raw & ~wr_data;
    end
    r_d.raw = r_d.raw | set_ev;
  end

  // Register the state.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r_q <= '{active: `ASQ_RST_ACTIVATE, raw: `ASQ_RST_RAW, mask: `ASQ_RST_MASK};
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the registers.
  assign sequencer_active_bit = r_q.active;
  assign raw_completion_flag = r_q.raw;
  assign irq_mask_q = r_q.mask;
  assign masked_status = r_q.raw & r_q.mask;
  assign adc_irq = |(r_q.raw & r_q.mask);

  a_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    adc_irq == |(raw_completion_flag & irq_mask_q)) else $error("irq level wrong");
  a_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
    |set_ev |=> ((raw_completion_flag & $past(set_ev)) == $past(set_ev))) else $error("set lost");
  a_clear_one: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_clear && set_ev == 4'h0 |=> ((raw_completion_flag & $past(wr_data)) == 4'h0)) else $error("clear failed");
  a_clear_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_clear |=> ((raw_completion_flag & ~$past(wr_data)) ==
      (($past(raw_completion_flag) | $past(set_ev)) & ~$past(wr_data)))) else $error("zero changed");
  a_no_spurious: assert property (@(posedge sys_clk) disable iff (!resetn)
    set_ev == 4'h0 |=> (raw_completion_flag & ~$past(raw_completion_flag)) == 4'h0) else $error("raw set");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_mask |=> irq_mask_q == $past(wr_data)) else $error("mask write");
endmodule

//--- hdl/asq_pkg.sv
package asq_pkg;
  // Four-bit vector, one bit per sequencer.
  typedef logic [3:0] asq_nib_t;

  // Bus access phase, one-hot.
  typedef enum logic [1:0] {
    ASQ_IDLE = 2'b01,
    ASQ_DATA = 2'b10
  } asq_phase_e;

  // Register file state.
  typedef struct packed {
    asq_nib_t active;
    asq_nib_t raw;
    asq_nib_t mask;
  } asq_regs_s;

  // Bus slave state.
  typedef struct packed {
    asq_phase_e phase;
    logic write;
    logic [11:0] addr;
    logic [31:0] rdata;
  } asq_bus_s;
endpackage

//--- sim/adc_sequencer_enable_irq_bench.sv
`timescale 1ns/100ps
`include "asq_cfg.svh"
module adc_sequencer_enable_irq_bench
  import asq_pkg::*;
;
  // ----------------------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic resp_q;
  logic [3:0] sample_done = 4'h0;
  logic [3:0] sample_irq_request = 4'h0;
  logic [3:0] sequencer_active_bit;
  logic adc_irq;
  logic [31:0] rd_q;
  int n_errors = 0;
  int comparisons = 0;
  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  // The clock runs at 50 MHz.
  always #10 sys_clk = ~sys_clk;
  asq_ahb_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_done(sample_done), .sample_irq_request(sample_irq_request),
    .sequencer_active_bit(sequencer_active_bit), .adc_irq(adc_irq));
  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One single word transfer; the wait ends only on a sampled ready.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd_q = hrdata;
    resp_q = hresp;
  endtask
  // Every read also checks that the slave answered OKAY.
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, exp, rd_q);
    check("hresp", 32'h0, {31'h0, resp_q});
  endtask
  // A one-cycle completion pulse from the sequencers.
  task automatic pulse(input logic [3:0] d, input logic [3:0] r);
    @(posedge sys_clk);
    sample_done <= d;
    sample_irq_request <= r;
    @(posedge sys_clk);
    sample_done <= 4'h0;
  endtask
  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  // Bounds a hang well beyond the hundred or so cycles the tests need.
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk("activate", `ASQ_OFS_ACTIVATE, 32'h0);
    rd_chk("raw", `ASQ_OFS_RAW, 32'h0);
    rd_chk("mask", `ASQ_OFS_MASK, 32'h0);
    rd_chk("status", `ASQ_OFS_STATUS, 32'h0);
    rd_chk("unmapped", 12'h010, 32'h0);
    // Upper bits written high must not stick.
    xfer(1'b1, `ASQ_OFS_ACTIVATE, 32'hFFFF_FFF5);
    rd_chk("activate", `ASQ_OFS_ACTIVATE, 32'h5);
    check("active_bits", 32'h5, {28'h0, sequencer_active_bit});
    xfer(1'b1, `ASQ_OFS_RAW, 32'hF);
    rd_chk("raw_nowrite", `ASQ_OFS_RAW, 32'h0);
    // Only enabled sequencers with the request bit set raise a flag.
    pulse(4'hF, 4'hB);
    rd_chk("raw_gated", `ASQ_OFS_RAW, 32'h1);
    // Software parks every sequencer before reprogramming; completions are then ignored.
    xfer(1'b1, `ASQ_OFS_ACTIVATE, 32'h0);
    pulse(4'hF, 4'hF);
    rd_chk("raw_parked", `ASQ_OFS_RAW, 32'h1);
    xfer(1'b1, `ASQ_OFS_ACTIVATE, 32'hF);
    pulse(4'hF, 4'hF);
    rd_chk("raw_polled", `ASQ_OFS_RAW, 32'hF);
    rd_chk("status_nomask", `ASQ_OFS_STATUS, 32'h0);
    check("irq_nomask", 32'h0, {31'h0, adc_irq});
    xfer(1'b1, `ASQ_OFS_MASK, 32'h6);
    rd_chk("status", `ASQ_OFS_STATUS, 32'h6);
    check("irq_level", 32'h1, {31'h0, adc_irq});
    xfer(1'b1, `ASQ_OFS_STATUS, 32'h0);
    rd_chk("raw_zero_wr", `ASQ_OFS_RAW, 32'hF);
    // Clearing an unmasked position still drops the raw flag.
    xfer(1'b1, `ASQ_OFS_STATUS, 32'h1);
    rd_chk("raw_clr_unmasked", `ASQ_OFS_RAW, 32'hE);
    check("irq_kept", 32'h1, {31'h0, adc_irq});
    xfer(1'b1, `ASQ_OFS_STATUS, 32'h6);
    rd_chk("raw_clr", `ASQ_OFS_RAW, 32'h8);
    rd_chk("status_clr", `ASQ_OFS_STATUS, 32'h0);
    check("irq_low", 32'h0, {31'h0, adc_irq});
    xfer(1'b1, 12'h010, 32'hF);
    rd_chk("mask_kept", `ASQ_OFS_MASK, 32'h6);
    close_out();
  end
endmodule
